// [rtl/brs_pkg.sv]
// boot/reset sequencer shared constants and types
// assumes a single 125 MHz device clock shared by both ends
package brs_pkg;
	localparam int          BRS_ADDR_W     = 10;
	localparam int          BRS_WORDS      = 256;
	localparam int          BRS_WIDX_W     = 8;
	localparam logic [31:0] BRS_START_ADDR = 32'h0000_0000;
	localparam logic [31:0] BRS_ROM_BASE   = 32'h9000_0000;
	localparam logic [7:0]  BRS_LAST_WORD  = 8'hff;
	localparam logic [1:0]  BRS_DBG_RESET  = 2'h0;

	typedef enum logic [1:0] {
		BRS_BOOT_HOST = 2'b00,
		BRS_BOOT_EMU  = 2'b01,
		BRS_BOOT_ROM8 = 2'b10,
		BRS_BOOT_ROM16 = 2'b11
	} brs_boot_t;

	typedef enum logic [2:0] {
		BRS_ST_RESET = 3'b000,
		BRS_ST_HOLD  = 3'b001,
		BRS_ST_COPY  = 3'b010,
		BRS_ST_WRITE = 3'b011,
		BRS_ST_RUN   = 3'b100
	} brs_state_t;

	localparam logic [1:0] BRS_ROM_BYTES8  = 2'h3;
	localparam logic [1:0] BRS_ROM_BYTES16 = 2'h1;
endpackage

// [rtl/brs_link_if.sv]
// link between the boot sequencer and the host/emulator/rom side
// assumes both ends share i_clk; the bench instantiates and joins them
interface brs_link_if;
	import brs_pkg::*;
	logic        host_wr;
	logic        host_rd;
	logic [9:0]  host_addr;
	logic [31:0] host_wdata;
	logic [31:0] host_rdata;
	logic        host_rvalid;
	logic        set_flag;
	logic        flag;
	logic        rom_req;
	logic [31:0] rom_addr;
	logic [15:0] rom_data;
	logic        rom_ack;
	logic        trst_n;
	logic [1:0]  dbg_pins;

	modport dev (
		input  host_wr, host_rd, host_addr, host_wdata, set_flag,
		input  rom_data, rom_ack, trst_n, dbg_pins,
		output host_rdata, host_rvalid, flag, rom_req, rom_addr
	);
	modport far (
		output host_wr, host_rd, host_addr, host_wdata, set_flag,
		output rom_data, rom_ack, trst_n, dbg_pins,
		input  host_rdata, host_rvalid, flag, rom_req, rom_addr
	);
endinterface

// [rtl/brs_far_end.sv]
// host / emulator / boot rom end of the boot link
// assumes the user side issues one host command per cycle at most
module brs_far_end
	import brs_pkg::*;
(
	input  wire logic        i_clk,         // device clock
	input  wire logic        i_reset_n,     // async reset, active low
	brs_link_if.far          lnk,           // link to the device
	input  wire logic        i_wr,          // host write request pulse
	input  wire logic        i_rd,          // host read request pulse
	input  wire logic [9:0]  i_addr,        // host byte address
	input  wire logic [31:0] i_wdata,       // host write data
	input  wire logic        i_set_flag,    // host/emulator sets the flag
	input  wire logic [15:0] i_rom_data,    // rom half-word at requested address
	input  wire logic        i_trst_n,      // test-port reset, active low
	input  wire logic [1:0]  i_dbg_pins,    // debug-configuration pins
	output logic [31:0]      o_rdata,       // host read data
	output logic             o_rvalid,      // host read data valid
	output logic [31:0]      o_rom_addr     // rom address being fetched
);
	// host commands are registered onto the link
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lnk.host_wr    <= 1'b0;
			lnk.host_rd    <= 1'b0;
			lnk.host_addr  <= '0;
			lnk.host_wdata <= '0;
			lnk.set_flag   <= 1'b0;
		end else begin
			lnk.host_wr    <= i_wr;
			lnk.host_rd    <= i_rd;
			lnk.host_addr  <= i_addr;
			lnk.host_wdata <= i_wdata;
			// set only if not already set
			lnk.set_flag   <= i_set_flag & ~lnk.flag;
		end
	end

	// rom answers one cycle after each request; contents in system byte order
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lnk.rom_ack  <= 1'b0;
			lnk.rom_data <= '0;
		end else begin
			lnk.rom_ack  <= lnk.rom_req & ~lnk.rom_ack;
			lnk.rom_data <= i_rom_data;
		end
	end

	// test-port reset and pins are passed registered
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lnk.trst_n   <= 1'b0;
			lnk.dbg_pins <= BRS_DBG_RESET;
		end else begin
			lnk.trst_n   <= i_trst_n;
			lnk.dbg_pins <= i_dbg_pins;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata    <= '0;
			o_rvalid   <= 1'b0;
			o_rom_addr <= '0;
		end else begin
			o_rdata    <= lnk.host_rdata;
			o_rvalid   <= lnk.host_rvalid;
			o_rom_addr <= lnk.rom_addr;
		end
	end
endmodule

// [rtl/brs_dev_end.sv]
// boot and reset sequencer, device end
// assumes one clock; the reset pin is synchronous-released by the system
// Operation
// - reset pin low holds whole chip reset
// - reset release starts with selected boot mode
// - host, emulation and rom boot paths
// - host boot stalls cpu, releases everything else
// - host may write memory during stall
// - host sets flag to finish boot
// - flag releases cpu, fetch from address 0
// - flag during stall not a pending interrupt
// - flag releases only under host-type boot
// - host may read back all memory
// - cpu clears flag; set flag blocks more
// - emulator sets flag if not set
// - emulator breakpoints address 0 first
// - rom boot copies 1k bytes to 0
// - rom width 8 or 16, assembled to 32
// - rom stored in system byte order
// - copy is one single-frame block transfer
// - copy done releases cpu from address 0
// - system asserts test and device reset
// - device boots with test reset held
// - latch debug pins on test reset rise
module brs_dev_end
	import brs_pkg::*;
(
	input  wire logic        i_clk,          // device clock
	input  wire logic        i_reset_n,      // device reset pin, active low
	brs_link_if.dev          lnk,            // link to host, emulator and rom
	input  wire logic [1:0]  i_boot_sel,     // boot path straps
	input  wire logic        i_big_endian,   // system byte order strap
	input  wire logic        i_cpu_clr_flag, // cpu clears the flag
	output logic             o_core_reset,   // internal reset to the rest of the chip
	output logic             o_cpu_stall,    // cpu held stalled
	output logic [31:0]      o_cpu_pc,       // first fetch address after release
	output logic             o_cpu_irq,      // host-to-cpu interrupt to the cpu
	output logic             o_test_reset,   // test port and emulation logic held
	output logic [1:0]       o_dbg_mode,     // latched debug-configuration pins
	output logic             o_dbg_valid,    // debug pins have been latched
	output logic             o_breakpoint_0  // emulation boot break at address 0
);
	brs_state_t  state_q;
	brs_boot_t   boot_q;
	logic        in_reset_q;
	logic        flag_q;
	logic [31:0] mem_q [BRS_WORDS];
	logic [BRS_WIDX_W-1:0] widx_q;
	logic [1:0]  part_q;
	logic [31:0] asm_q;
	logic        trst_q;
	logic [1:0]  parts_last;
	logic [1:0]  rom_off;
	logic [31:0] asm_next;

	function automatic logic boot_is_rom(input brs_boot_t b);
		return (b == BRS_BOOT_ROM8) || (b == BRS_BOOT_ROM16);
	endfunction

	function automatic logic boot_is_hostlike(input brs_boot_t b);
		return (b == BRS_BOOT_HOST) || (b == BRS_BOOT_EMU);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset and boot path capture
	// the straps are caught by a clock edge while reset is held, never by the async term
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			in_reset_q <= 1'b1;
		else
			in_reset_q <= 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (in_reset_q)
			boot_q <= brs_boot_t'(i_boot_sel);
	end

	////////////////////////////////////////////////////////////////////////
	// boot sequencing
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= BRS_ST_RESET;
		end else begin
			case (state_q)
				BRS_ST_RESET:
					state_q <= boot_is_rom(boot_q) ? BRS_ST_COPY : BRS_ST_HOLD;
				BRS_ST_HOLD:
					// flag releases only host and emulation paths
					if (lnk.set_flag && boot_is_hostlike(boot_q))
						state_q <= BRS_ST_RUN;
				BRS_ST_COPY:
					// the word is complete only once its last part has been taken
					if (lnk.rom_ack && part_q == parts_last)
						state_q <= BRS_ST_WRITE;
				BRS_ST_WRITE:
					// single frame: one pass over the whole block, no restart
					state_q <= (widx_q == BRS_LAST_WORD) ? BRS_ST_RUN : BRS_ST_COPY;
				BRS_ST_RUN:
					state_q <= BRS_ST_RUN;
				default:
					state_q <= BRS_ST_RESET;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// rom copy with width assembly
	always_comb begin
		parts_last = (boot_q == BRS_BOOT_ROM8) ? BRS_ROM_BYTES8 : BRS_ROM_BYTES16;
		// halfwords sit two bytes apart, so the part index moves one bit up
		rom_off    = (boot_q == BRS_BOOT_ROM8) ? part_q : {part_q[0], 1'b0};
		asm_next   = asm_q;
		// fill from the top for big endian, from the bottom for little
		if (boot_q == BRS_BOOT_ROM8) begin
			if (i_big_endian)
				asm_next = {asm_q[23:0], lnk.rom_data[7:0]};
			else
				asm_next = {lnk.rom_data[7:0], asm_q[31:8]};
		end else begin
			if (i_big_endian)
				asm_next = {asm_q[15:0], lnk.rom_data};
			else
				asm_next = {lnk.rom_data, asm_q[31:16]};
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			part_q <= '0;
			asm_q  <= '0;
			widx_q <= '0;
		end else if (state_q == BRS_ST_COPY && lnk.rom_ack) begin
			asm_q  <= asm_next;
			part_q <= (part_q == parts_last) ? 2'h0 : part_q + 2'h1;
		end else if (state_q == BRS_ST_WRITE) begin
			widx_q <= widx_q + 8'h01;
		end
	end

	// one request outstanding at a time; the rom answers with rom_ack
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lnk.rom_req  <= 1'b0;
			lnk.rom_addr <= '0;
		end else begin
			lnk.rom_req  <= (state_q == BRS_ST_COPY) && !lnk.rom_req && !lnk.rom_ack;
			lnk.rom_addr <= BRS_ROM_BASE + {22'h0, widx_q, rom_off};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory: rom copy writes, host writes in hold state, host reads at any time
	always_ff @(posedge i_clk) begin
		if (state_q == BRS_ST_WRITE)
			mem_q[widx_q] <= asm_q;
		else if (state_q == BRS_ST_HOLD && lnk.host_wr)
			mem_q[lnk.host_addr[9:2]] <= lnk.host_wdata;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lnk.host_rdata  <= '0;
			lnk.host_rvalid <= 1'b0;
		end else begin
			lnk.host_rvalid <= lnk.host_rd && !in_reset_q;
			if (lnk.host_rd)
				lnk.host_rdata <= mem_q[lnk.host_addr[9:2]];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host-to-cpu interrupt flag
	// set wins over the cpu clear; a set in hold state only releases the cpu, one during the rom copy releases nothing
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			flag_q <= 1'b0;
		else if (lnk.set_flag)
			flag_q <= 1'b1;
		else if (i_cpu_clr_flag && state_q == BRS_ST_RUN)
			flag_q <= 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lnk.flag  <= 1'b0;
			o_cpu_irq <= 1'b0;
		end else begin
			lnk.flag  <= flag_q;
			// only a fresh set in run state interrupts the cpu
			o_cpu_irq <= lnk.set_flag && !flag_q && state_q == BRS_ST_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cpu and core outputs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_core_reset   <= 1'b1;
			o_cpu_stall    <= 1'b1;
			o_cpu_pc       <= BRS_START_ADDR;
			o_breakpoint_0 <= 1'b0;
		end else begin
			o_core_reset   <= in_reset_q;
			o_cpu_stall    <= state_q != BRS_ST_RUN;
			o_cpu_pc       <= BRS_START_ADDR;
			o_breakpoint_0 <= boot_q == BRS_BOOT_EMU && !in_reset_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// test-port reset and debug pin latch
	// boot never waits on the test reset, which may stay low forever
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			trst_q       <= 1'b0;
			o_test_reset <= 1'b1;
			o_dbg_mode   <= BRS_DBG_RESET;
			o_dbg_valid  <= 1'b0;
		end else begin
			trst_q       <= lnk.trst_n;
			o_test_reset <= !lnk.trst_n;
			if (lnk.trst_n && !trst_q) begin
				o_dbg_mode  <= lnk.dbg_pins;
				o_dbg_valid <= 1'b1;
			end
		end
	end
endmodule

// [verif/brs_link_chk.sv]
// assertions on the boot link joining the two ends
// assumes the bench hands over the interface signals with the device clock and reset
module brs_link_chk
	import brs_pkg::*;
(
	input wire logic        i_clk,       // device clock
	input wire logic        i_reset_n,   // device reset, active low
	input wire logic        host_rd,     // host read strobe
	input wire logic        host_rvalid, // host read answer
	input wire logic        set_flag,    // flag set request
	input wire logic        flag,        // host-to-cpu flag
	input wire logic        rom_req,     // rom fetch request
	input wire logic        rom_ack,     // rom fetch answer
	input wire logic [31:0] rom_addr     // rom fetch address
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] last_q;
	logic        seen_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			seen_q <= 1'b0;
			last_q <= 32'h0;
		end else if (rom_req) begin
			seen_q <= 1'b1;
			last_q <= rom_addr;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_rd_answer;
		host_rd |=> host_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rv_cause;
		host_rvalid |-> $past(host_rd);
	endproperty
	a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
	property p_rom_ack;
		rom_req |=> rom_ack && !rom_req;
	endproperty
	a_rom_ack: assert property (p_rom_ack) else $error("rom fetch not acked");
	property p_rom_window;
		rom_req |-> (rom_addr - BRS_ROM_BASE) < 32'h400;
	endproperty
	a_rom_window: assert property (p_rom_window) else $error("rom fetch off window");
	// fetches only move forward: consecutive parts feed one word
	property p_rom_rising;
		rom_req && seen_q |-> rom_addr > last_q;
	endproperty
	a_rom_rising: assert property (p_rom_rising) else $error("rom fetch out of order");
	property p_flag_cause;
		$rose(flag) |-> $past(set_flag, 2);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag set unasked");
	property p_flag_set;
		set_flag |-> ##2 flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");
	property p_set_guard;
		set_flag |-> !$past(flag);
	endproperty
	a_set_guard: assert property (p_set_guard) else $error("flag set twice");
endmodule

// [verif/boot_reset_sequencer_tb.sv]
// self-checking bench: far end and device end joined by the boot link
// assumes rtl package, interface and both ends are compiled first
module boot_reset_sequencer_tb
	import brs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0; // both resets low from power-up
	logic        wr = 1'b0, rd = 1'b0, set_f = 1'b0, trst_n = 1'b0, be = 1'b0, clr = 1'b0;
	logic [9:0]  addr = 10'h0;
	logic [31:0] wdata = 32'h0, rdata, rom_a, pc;
	logic [15:0] rom_d;
	logic [1:0]  sel = 2'h0, dbg = 2'h0, dmode;
	logic        rvalid, core_rst, stall, irq, trst_o, dvalid, bp;
	int          err_count = 0, n_compared = 0, n_req = 0, n_irq = 0, n_ack = 0;
	always #4 clk = ~clk;
	brs_link_if lnk ();
	// rom content follows the link address so that order and packing both show;
	// the far end takes the data on the edge it sees the request, so answer that address
	assign rom_d = {lnk.rom_addr[7:0] ^ 8'hc3, lnk.rom_addr[7:0]};
	always @(posedge clk) if (lnk.rom_req) n_req++;
	always @(posedge clk) if (lnk.rom_ack) n_ack++;
	always @(posedge clk) if (irq) n_irq++;
	////////////////////////////////////////////////////////////////////////////////
	brs_far_end brs_far_end_inst (.i_clk(clk), .i_reset_n(rst_n), .lnk(lnk.far), .i_wr(wr),
		.i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_set_flag(set_f), .i_rom_data(rom_d),
		.i_trst_n(trst_n), .i_dbg_pins(dbg), .o_rdata(rdata), .o_rvalid(rvalid), .o_rom_addr(rom_a));
	brs_dev_end brs_dev_end_inst (.i_clk(clk), .i_reset_n(rst_n), .lnk(lnk.dev), .i_boot_sel(sel),
		.i_big_endian(be), .i_cpu_clr_flag(clr), .o_core_reset(core_rst), .o_cpu_stall(stall),
		.o_cpu_pc(pc), .o_cpu_irq(irq), .o_test_reset(trst_o), .o_dbg_mode(dmode),
		.o_dbg_valid(dvalid), .o_breakpoint_0(bp));
	brs_link_chk brs_link_chk_inst (.i_clk(clk), .i_reset_n(rst_n), .host_rd(lnk.host_rd),
		.host_rvalid(lnk.host_rvalid), .set_flag(lnk.set_flag), .flag(lnk.flag),
		.rom_req(lnk.rom_req), .rom_ack(lnk.rom_ack), .rom_addr(lnk.rom_addr));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic boot(input logic [1:0] s, input logic b);
		@(negedge clk);
		rst_n = 1'b0;
		sel = s;
		be = b;
		repeat (20) @(negedge clk);
		n_req = 0;
		n_ack = 0;
		check(32'(core_rst), 32'h1);
		check(32'(stall), 32'h1);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		check(32'(core_rst), 32'h0);
	endtask
	task automatic pulse_set();
		@(negedge clk);
		set_f = 1'b1;
		@(negedge clk);
		set_f = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic hwrite(input logic [9:0] a, input logic [31:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic hread(input logic [9:0] a, input logic [31:0] exp);
		int n;
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		for (n = 0; n < 8 && rvalid !== 1'b1; n++) @(negedge clk);
		check(32'(rvalid), 32'h1);
		check(rdata, exp);
	endtask
	function automatic logic [31:0] exp_word(input logic [7:0] a, input logic [1:0] s,
		input logic b);
		logic [15:0] h0, h2;
		h0 = {a ^ 8'hc3, a};
		h2 = {(a + 8'h2) ^ 8'hc3, a + 8'h2};
		if (s == BRS_BOOT_ROM8) return b ? {a, a + 8'h1, a + 8'h2, a + 8'h3}
			: {a + 8'h3, a + 8'h2, a + 8'h1, a};
		return b ? {h0, h2} : {h2, h0};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_host();
		boot(BRS_BOOT_HOST, 1'b0);
		hwrite(10'h000, 32'h1234_5678);
		hwrite(10'h3fc, 32'hcafe_0001);
		hread(10'h000, 32'h1234_5678);
		hread(10'h3fc, 32'hcafe_0001);
		check(32'(stall), 32'h1);
		check(32'(bp), 32'h0);
		n_irq = 0;
		pulse_set();
		check(32'(stall), 32'h0);
		check(pc, BRS_START_ADDR);
		pulse_set();
		check(32'(n_irq), 32'h0);
		@(negedge clk);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		pulse_set();
		check(32'(n_irq), 32'h1);
		// writes are closed once the cpu runs
		hwrite(10'h000, 32'h0);
		hread(10'h000, 32'h1234_5678);
		$display("host boot test done");
	endtask
	task automatic t_emu();
		boot(BRS_BOOT_EMU, 1'b1);
		check(32'(bp), 32'h1);
		check(32'(stall), 32'h1);
		pulse_set();
		check(32'(stall), 32'h0);
		$display("emulation boot test done");
	endtask
	task automatic t_rom(input logic [1:0] s, input logic b);
		int n, step;
		boot(s, b);
		step = (s == BRS_BOOT_ROM8) ? 1 : 2;
		sel = BRS_BOOT_HOST;
		pulse_set();
		check(32'(stall), 32'h1);
		for (n = 0; n < 6000 && stall !== 1'b0; n++) begin
			// the far end shows the fetched byte address while the answer stands
			if (lnk.rom_ack === 1'b1)
				check(rom_a, BRS_ROM_BASE + 32'(step * n_ack));
			@(negedge clk);
		end
		check(32'(stall), 32'h0);
		check(32'(n_req), s == BRS_BOOT_ROM8 ? 32'd1024 : 32'd512);
		check(pc, BRS_START_ADDR);
		hread(10'h000, exp_word(8'h00, s, b));
		hread(10'h3fc, exp_word(8'hfc, s, b));
		$display("rom boot test done");
	endtask
	task automatic t_trst();
		check(32'(trst_o), 32'h1);
		check(32'(dvalid), 32'h0);
		dbg = 2'h2;
		@(negedge clk);
		trst_n = 1'b1;
		repeat (4) @(negedge clk);
		check(32'(dmode), 32'h2);
		check(32'(dvalid), 32'h1);
		check(32'(trst_o), 32'h0);
		$display("test reset test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		t_host();
		t_emu();
		for (int i = 0; i < 4; i++) t_rom(i[1] ? BRS_BOOT_ROM16 : BRS_BOOT_ROM8, i[0]);
		t_trst();
		finish_test();
	end
	// four rom copies of up to some 3300 cycles each dominate the run
	initial begin
		#400000;
		err_count++;
		finish_test();
	end
endmodule
